// ==== shared/dawc_pkg.sv ====
package dawc_pkg;
  // Memory-mapped control register
  localparam logic [19:0] DAWC_CTL_OFFSET = 20'h45000;
  localparam logic [31:0] DAWC_CTL_RESET  = 32'hc2240622;
  localparam int          DAWC_ADDR_MIN   = 19;
  // Field positions in the control register
  localparam int DAWC_CMP_WAKE_BIT = 31;
  localparam int DAWC_REM_WAKE_BIT = 30;
  localparam int DAWC_OPP_MODE_BIT = 29;
  localparam int DAWC_RSVD_BIT     = 28;
  // Self refresh phase as seen by the arbiter
  typedef enum logic [1:0] {
    DAWC_AWAKE,
    DAWC_SLEEP,
    DAWC_WAKING
  } dawc_phase_e;
endpackage

// ==== shared/dawc_client_if.sv ====
`timescale 1ns/1ps
interface dawc_client_if;
  logic req;
  logic wake_en;
  logic in_sr;
  logic wake;
  logic grant;
  logic pending;
  modport gate (input req, input wake_en, input in_sr,
                output wake, output grant, output pending);
  modport arb  (output req, output wake_en, output in_sr,
                input wake, input grant, input pending);
endinterface

// ==== rtl/dawc_wake_gate.sv ====
`timescale 1ns/1ps
module dawc_wake_gate
  import dawc_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst_n,
  dawc_client_if.gate cl
);
  typedef struct packed {
    logic pending;
    logic grant;
    logic wake;
  } dawc_gate_s;

  dawc_gate_s s;
  dawc_gate_s next_s;

  // Held request: served once memory is out of self refresh
  always_comb begin
    next_s         = s;
    next_s.grant   = s.pending && !cl.in_sr;
    // A new request in the grant cycle is kept, set beats clear
    next_s.pending = cl.req || (s.pending && cl.in_sr);
    // Wake only while allowed; otherwise the request just waits
    next_s.wake    = (s.pending || cl.req) && cl.wake_en
                     && cl.in_sr;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cl.pending = s.pending;
  assign cl.grant   = s.grant;
  assign cl.wake    = s.wake;

  property p_held_not_lost;
    @(posedge clock) disable iff (!rst_n)
      cl.req && cl.in_sr |=> s.pending;
  endproperty
  a_held_not_lost: assert property (p_held_not_lost)
    else $error("request in self refresh was dropped");

  // Without a fresh request the grant is one pulse and clears pending
  property p_grant_on_exit;
    @(posedge clock) disable iff (!rst_n)
      s.pending && !cl.in_sr && !cl.req
        |=> s.grant && !s.pending ##1 !s.grant;
  endproperty
  a_grant_on_exit: assert property (p_grant_on_exit)
    else $error("held request not granted after self refresh");

  property p_wake_needs_enable;
    @(posedge clock) disable iff (!rst_n)
      s.wake |-> $past(cl.wake_en) && $past(cl.in_sr);
  endproperty
  a_wake_needs_enable: assert property (p_wake_needs_enable)
    else $error("wake raised without its enable");
endmodule

// ==== rtl/dawc_arbiter.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Control register is 32-bit RW at 45000h, reset value c2240622h.
// - Bit 31 set lets compressor writes wake memory from self refresh.
// - Bit 30 set lets remote console write-backs wake memory.
// - Bit 29 set allows opportunistic display fetch when others wake memory.
// - No opportunistic fetch when the display itself is waking memory.
// - Bit 28 is reserved and changes nothing in arbitration.
module dawc_arbiter
  import dawc_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic              mem_self_refresh,
  input  wire logic              compressor_req,
  output logic                   compressor_grant,
  output logic                   compressor_pending,
  input  wire logic              remote_req,
  output logic                   remote_grant,
  output logic                   remote_pending,
  input  wire logic              display_wake_req,
  input  wire logic              other_wake_req,
  output logic                   mem_wake,
  output logic                   opp_fetch
);
  // Offset must fit in the address port
  if (ADDR_W < DAWC_ADDR_MIN) begin : g_addr_check
    $error("ADDR_W too narrow for the control register offset");
  end

  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] rdata;
    logic        rvalid;
    logic        prev_sr;
    logic        disp_woke;
    logic        other_woke;
    logic        mem_wake;
    logic        opp_fetch;
    dawc_phase_e phase;
  } dawc_arb_s;

  dawc_arb_s s;
  dawc_arb_s next_s;

  dawc_client_if cmp_if ();
  dawc_client_if rem_if ();

  logic hit;
  logic sr_exit;
  logic other_wake;

  // Cast, not a part-select: wider address ports stay legal
  assign hit = reg_addr == ADDR_W'(DAWC_CTL_OFFSET);
  assign sr_exit = s.prev_sr && !mem_self_refresh;
  assign other_wake = cmp_if.wake || rem_if.wake || other_wake_req;

  // Compressor and remote console each get their own hold-and-wake gate
  assign cmp_if.req     = compressor_req;
  assign cmp_if.wake_en = s.ctl[DAWC_CMP_WAKE_BIT];
  assign cmp_if.in_sr   = mem_self_refresh;
  assign rem_if.req     = remote_req;
  assign rem_if.wake_en = s.ctl[DAWC_REM_WAKE_BIT];
  assign rem_if.in_sr   = mem_self_refresh;

  dawc_wake_gate u_cmp_gate (
    .clock (clock),
    .rst_n (rst_n),
    .cl    (cmp_if)
  );

  dawc_wake_gate u_rem_gate (
    .clock (clock),
    .rst_n (rst_n),
    .cl    (rem_if)
  );

  // Register access, wake merging and fetch decision
  always_comb begin
    next_s           = s;
    next_s.rvalid    = reg_rd;
    next_s.rdata     = '0;
    if (reg_rd && hit) begin
      next_s.rdata = s.ctl;
    end
    // Bit 28 is stored but read by no arbitration logic
    if (reg_wr && hit) begin
      next_s.ctl = reg_wdata;
    end
    next_s.prev_sr   = mem_self_refresh;
    // Only enabled gates raise wake; held ones just wait
    next_s.mem_wake  = mem_self_refresh
                       && (other_wake || display_wake_req);
    next_s.opp_fetch = 1'b0;
    case (s.phase)
      DAWC_AWAKE: begin
        // A wake in the first self refresh cycle must count too
        next_s.disp_woke  = mem_self_refresh && display_wake_req;
        next_s.other_woke = mem_self_refresh && other_wake;
        if (mem_self_refresh) begin
          next_s.phase = DAWC_SLEEP;
        end
      end
      DAWC_SLEEP, DAWC_WAKING: begin
        // Remember who caused the wake until the exit edge
        if (display_wake_req) begin
          next_s.disp_woke = 1'b1;
        end
        if (other_wake) begin
          next_s.other_woke = 1'b1;
        end
        if (display_wake_req || other_wake) begin
          next_s.phase = DAWC_WAKING;
        end
        if (sr_exit || !mem_self_refresh) begin
          next_s.phase      = DAWC_AWAKE;
          // Fetch regardless of watermark, but never on own wake
          next_s.opp_fetch  = s.ctl[DAWC_OPP_MODE_BIT]
                              && s.other_woke
                              && !s.disp_woke;
          next_s.disp_woke  = 1'b0;
          next_s.other_woke = 1'b0;
        end
      end
      default: begin
        next_s.phase = DAWC_AWAKE;
      end
    endcase
  end

  // Reset loads the documented control value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.ctl   <= DAWC_CTL_RESET;
      s.phase <= DAWC_AWAKE;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata          = s.rdata;
  assign reg_rvalid         = s.rvalid;
  assign mem_wake           = s.mem_wake;
  assign opp_fetch          = s.opp_fetch;
  assign compressor_grant   = cmp_if.grant;
  assign compressor_pending = cmp_if.pending;
  assign remote_grant       = rem_if.grant;
  assign remote_pending     = rem_if.pending;

  property p_write_readback;
    @(posedge clock) disable iff (!rst_n)
      reg_wr && hit && !reg_rd ##1 reg_rd && hit && !reg_wr
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_write_readback: assert property (p_write_readback)
    else $error("control register readback mismatch");

  property p_cmp_wake;
    @(posedge clock) disable iff (!rst_n)
      compressor_req && s.ctl[DAWC_CMP_WAKE_BIT] && mem_self_refresh
        ##1 mem_self_refresh && !reg_wr |=> mem_wake;
  endproperty
  a_cmp_wake: assert property (p_cmp_wake)
    else $error("compressor request did not wake memory");

  property p_rem_wake;
    @(posedge clock) disable iff (!rst_n)
      remote_req && s.ctl[DAWC_REM_WAKE_BIT] && mem_self_refresh
        ##1 mem_self_refresh && !reg_wr |=> mem_wake;
  endproperty
  a_rem_wake: assert property (p_rem_wake)
    else $error("remote console request did not wake memory");

  property p_opp_fetch;
    @(posedge clock) disable iff (!rst_n)
      s.phase != DAWC_AWAKE && !mem_self_refresh && s.other_woke
        && !s.disp_woke && s.ctl[DAWC_OPP_MODE_BIT] |=> opp_fetch;
  endproperty
  a_opp_fetch: assert property (p_opp_fetch)
    else $error("opportunistic fetch missing after foreign wake");

  property p_no_own_fetch;
    @(posedge clock) disable iff (!rst_n)
      opp_fetch |-> !$past(s.disp_woke) && $past(s.ctl[DAWC_OPP_MODE_BIT]);
  endproperty
  a_no_own_fetch: assert property (p_no_own_fetch)
    else $error("opportunistic fetch while display was waking");

  property p_wake_cause;
    @(posedge clock) disable iff (!rst_n)
      mem_wake |-> $past(cmp_if.wake || rem_if.wake || other_wake_req
                         || display_wake_req);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("memory wake without a client cause");

  property p_disabled_holds;
    @(posedge clock) disable iff (!rst_n)
      compressor_req && !s.ctl[DAWC_CMP_WAKE_BIT] && mem_self_refresh
        |=> compressor_pending;
  endproperty
  a_disabled_holds: assert property (p_disabled_holds)
    else $error("disabled compressor request not held");

  // Unmapped reads still answer, with zero data
  property p_unmapped_read;
    @(posedge clock) disable iff (!rst_n)
      reg_rd && !hit |=> reg_rvalid && reg_rdata == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned data");

  // Display wake just before exit must still block the fetch
  property p_own_wake_blocks;
    @(posedge clock) disable iff (!rst_n)
      mem_self_refresh && display_wake_req ##1 !mem_self_refresh
        |=> !opp_fetch;
  endproperty
  a_own_wake_blocks: assert property (p_own_wake_blocks)
    else $error("opportunistic fetch after display wake");
endmodule

// ==== testbench/dawc_mem_model.sv ====
`timescale 1ns/1ps
module dawc_mem_model #(
  parameter int EXIT_DLY = 3
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enter,
  input  wire logic wake,
  output logic      self_refresh
);
  int cnt;
  // Slow exit: wake must be held some cycles, as real memory needs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      self_refresh <= 1'b0;
      cnt <= 0;
    end else if (enter) begin
      self_refresh <= 1'b1;
      cnt <= 0;
    end else if (self_refresh && wake) begin
      cnt <= cnt + 1;
      if (cnt >= EXIT_DLY) begin
        self_refresh <= 1'b0;
      end
    end
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import dawc_pkg::*;
  logic        clock, rst_n, reg_wr, reg_rd, reg_rvalid, sr, enter;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        c_req, c_gnt, c_pnd, r_req, r_gnt, r_pnd;
  logic        d_wk, o_wk, mem_wake, opp, woke;
  logic [31:0] exp_q[$];
  int          n_errors, n_checks, n_cg, n_rg, n_opp;

  dawc_arbiter #(.ADDR_W(20)) u_dawc_arbiter (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mem_self_refresh(sr),
    .compressor_req(c_req), .compressor_grant(c_gnt),
    .compressor_pending(c_pnd), .remote_req(r_req), .remote_grant(r_gnt),
    .remote_pending(r_pnd), .display_wake_req(d_wk),
    .other_wake_req(o_wk), .mem_wake(mem_wake), .opp_fetch(opp));
  dawc_mem_model u_dawc_mem_model (
    .clock(clock), .rst_n(rst_n), .enter(enter), .wake(mem_wake),
    .self_refresh(sr));

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [19:0] a, logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
  endtask
  // Expected read data noted before the strobe goes out
  task automatic rd(logic [19:0] a, logic [31:0] e);
    reg_addr = a;
    exp_q.push_back(e);
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
  endtask
  // One sleep period: requests in self refresh, then forced exit if still asleep
  task automatic nap(logic [31:0] ctl, logic c, logic r, logic dw);
    logic ew;
    ew = (c & ctl[31]) | (r & ctl[30]) | dw;
    wr(DAWC_CTL_OFFSET, ctl);
    enter = 1'b1;
    step();
    enter = 1'b0;
    step();
    {n_cg, n_rg, n_opp, woke} = '0;
    c_req = c;
    r_req = r;
    d_wk = dw;
    step();
    c_req = 1'b0;
    r_req = 1'b0;
    step(10);
    chk("mem_wake", {31'h0, ew}, {31'h0, woke});
    if (!ew) chk("pending", {30'h0, c, r}, {30'h0, c_pnd, r_pnd});
    // Foreign wake only while still asleep, so no zero-width pulse
    if (sr === 1'b1) begin
      o_wk = 1'b1;
      for (int i = 0; i < 50 && sr === 1'b1; i++) step();
    end
    {o_wk, d_wk} = '0;
    step(6);
    chk("grants", {30'h0, c, r}, n_cg * 2 + n_rg);
    chk("opp", {31'h0, ctl[29] & ~dw}, n_opp);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read monitor takes the oldest note; pulses are counted as they come
  always @(posedge clock) begin
    if (reg_rvalid === 1'b1) begin
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    if (c_gnt === 1'b1) n_cg++;
    if (r_gnt === 1'b1) n_rg++;
    if (opp === 1'b1) n_opp++;
    if (mem_wake === 1'b1) woke = 1'b1;
  end
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Watchdog well past the expected run length
  initial begin
    #50000;
    n_errors++;
    end_of_test();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, enter, c_req, r_req, d_wk, o_wk} = '0;
    {reg_addr, reg_wdata, d, woke} = '0;
    void'($urandom(32'h1ea2));
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    step(2);
    rd(DAWC_CTL_OFFSET, DAWC_CTL_RESET);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(DAWC_CTL_OFFSET, d);
      rd(DAWC_CTL_OFFSET, d);
    end
    wr(DAWC_CTL_OFFSET + 20'h4, ~d);
    rd(DAWC_CTL_OFFSET + 20'h4, 32'h0);
    // Let an edge pass so the read strobe is not set twice at once
    step();
    rd(DAWC_CTL_OFFSET, d);
    // Awake requests are served without any wake
    {n_cg, n_rg} = '0;
    c_req = 1'b1;
    r_req = 1'b1;
    step();
    {c_req, r_req} = '0;
    step(4);
    chk("awake_grants", 32'h3, n_cg * 2 + n_rg);
    nap(DAWC_CTL_RESET, 1'b1, 1'b0, 1'b0);
    nap(32'h0000_0000, 1'b1, 1'b1, 1'b0);
    nap(32'h4000_0000, 1'b0, 1'b1, 1'b0);
    nap(32'h8000_0000, 1'b0, 1'b1, 1'b0);
    nap(32'h2000_0000, 1'b1, 1'b0, 1'b0);
    nap(32'he000_0000, 1'b1, 1'b1, 1'b1);
    nap(32'h1000_0000, 1'b0, 1'b0, 1'b0);
    nap(32'h3000_0000, 1'b0, 1'b0, 1'b0);
    step(4);
    chk("reads_left", 32'h0, exp_q.size());
    end_of_test();
  end
endmodule
